// ### inc/hufc_defines.svh
`ifndef HUFC_DEFINES_SVH
`define HUFC_DEFINES_SVH

// ============================================================
// clocking and line rates
`define HUFC_CLK_HZ       20000000
`define HUFC_APP_BAUD     115200
`define HUFC_DBG_BAUD     9600
// clocks per bit, rounded to the nearest whole cycle
`define HUFC_APP_DIV      16'((`HUFC_CLK_HZ + `HUFC_APP_BAUD / 2) / `HUFC_APP_BAUD)
`define HUFC_DBG_DIV      16'((`HUFC_CLK_HZ + `HUFC_DBG_BAUD / 2) / `HUFC_DBG_BAUD)

// ============================================================
// idle period after a device packet, in bit times, and in clocks
`define HUFC_TX_GAP_BITS  10
`define HUFC_TX_GAP_CYC   16'(`HUFC_TX_GAP_BITS * `HUFC_APP_DIV)

// ============================================================
// framing bytes
`define HUFC_HDLC_FLAG    8'h7e
`define HUFC_HDLC_ESC     8'h7d
`define HUFC_HDLC_XOR     8'h20

// ============================================================
// pin reset values, and index of the last timestamp byte
`define HUFC_PINS_RST     6'h3e
`define HUFC_TS_LAST_IDX  2'h3

`endif

// ### inc/hufc_pkg.sv
package hufc_pkg;

    // ============================================================
    // device packet transmit states
    typedef enum logic [2:0] {
        S_IDLE  = 3'b000,
        S_REQ   = 3'b001,
        S_OPEN  = 3'b010,
        S_DATA  = 3'b011,
        S_ESC   = 3'b100,
        S_CLOSE = 3'b101,
        S_GAP   = 3'b110
    } hufc_tx_st_t;

    // ============================================================
    // pins sampled from the host side, all asynchronous
    typedef struct packed {
        logic app_rxd;
        logic dbg_rxd;
        logic host_rts_n;
        logic host_cts_n;
        logic time_n;
        logic radio_inhibit;
    } hufc_pins_t;

    // ============================================================
    // one payload byte of an outgoing packet
    typedef struct packed {
        logic [7:0] data;
        logic       last;
    } hufc_byte_t;

endpackage : hufc_pkg

// ### design/hufc_uart_core.sv
`timescale 1ns/10ps
`default_nettype none

// ============================================================
// 8N1 transmitter and receiver; rxd must arrive synchronised
module hufc_uart_core #(
    parameter logic [15:0] DIV = 16'h00ae
) (
    input  wire logic       clock,
    input  wire logic       rst_b,
    input  wire logic       rxd,
    input  wire logic [7:0] tx_data,
    input  wire logic       tx_valid,
    output logic            tx_ready,
    output logic            txd,
    output logic [7:0]      rx_data,
    output logic            rx_valid,
    output logic            rx_busy
);
    localparam logic [15:0] DIV_M1  = DIV - 16'h0001;
    localparam logic [15:0] HALF    = DIV >> 1;

    logic [9:0]  tx_sh_q;   // stop, data lsb first, start
    logic [3:0]  tx_bits_q; // bits left to send
    logic [15:0] tx_cnt_q;  // clocks left in this bit
    logic [3:0]  rx_bits_q; // 10 start check, 9..2 data, 1 stop
    logic [15:0] rx_cnt_q;
    logic [7:0]  rx_sh_q;
    logic        rx_valid_q;
    logic [7:0]  rx_data_q;

    wire tx_tick  = (tx_cnt_q == 16'h0000);
    wire rx_tick  = (rx_cnt_q == 16'h0000);
    wire tx_load  = tx_valid && tx_ready;

    assign tx_ready = (tx_bits_q == 4'h0);
    assign txd      = tx_sh_q[0];   // idle shift value is all ones
    assign rx_data  = rx_data_q;
    assign rx_valid = rx_valid_q;
    assign rx_busy  = (rx_bits_q != 4'h0);

    // transmit shifter: start bit low, eight data lsb first, stop high
    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            tx_sh_q   <= 10'h3ff;
            tx_bits_q <= 4'h0;
            tx_cnt_q  <= 16'h0000;
        end else if (tx_load) begin
            tx_sh_q   <= {1'b1, tx_data, 1'b0};
            tx_bits_q <= 4'ha;
            tx_cnt_q  <= DIV_M1;
        end else if (!tx_ready) begin
            if (tx_tick) begin
                tx_sh_q   <= {1'b1, tx_sh_q[9:1]};
                tx_bits_q <= tx_bits_q - 4'h1;
                tx_cnt_q  <= DIV_M1;
            end else begin
                tx_cnt_q  <= tx_cnt_q - 16'h0001;
            end
        end
    end

    // receiver watches the line all the time; a short low is a glitch
    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            rx_bits_q  <= 4'h0;
            rx_cnt_q   <= 16'h0000;
            rx_sh_q    <= 8'h00;
            rx_valid_q <= 1'b0;
            rx_data_q  <= 8'h00;
        end else begin
            rx_valid_q <= 1'b0;
            if (rx_bits_q == 4'h0) begin
                if (!rxd) begin
                    rx_bits_q <= 4'ha;
                    rx_cnt_q  <= HALF;
                end
            end else if (!rx_tick) begin
                rx_cnt_q <= rx_cnt_q - 16'h0001;
            end else begin
                rx_cnt_q <= DIV_M1;
                if (rx_bits_q == 4'ha) begin
                    rx_bits_q <= rxd ? 4'h0 : 4'h9;
                end else if (rx_bits_q == 4'h1) begin
                    // one stop bit, no parity; a low stop drops the byte
                    rx_bits_q  <= 4'h0;
                    rx_valid_q <= rxd;
                    rx_data_q  <= rx_sh_q;
                end else begin
                    rx_sh_q   <= {rxd, rx_sh_q[7:1]};
                    rx_bits_q <= rx_bits_q - 4'h1;
                end
            end
        end
    end

    // ============================================================
    // checks
    start_bit_a:
    assert property (@(posedge clock) disable iff (!rst_b)
        tx_load |=> !txd [*2]) else $error("start bit not low");

    stop_bit_a:
    assert property (@(posedge clock) disable iff (!rst_b)
        (tx_bits_q == 4'h1) |-> txd) else $error("stop bit not high");

endmodule : hufc_uart_core

`default_nettype wire

// ### design/hufc_host_uart.sv
`timescale 1ns/10ps
`default_nettype none
`include "hufc_defines.svh"

module hufc_host_uart (
    input  wire logic               clock,
    input  wire logic               rst_b,
    // application port pins
    input  wire logic               app_rxd,
    output logic                    app_txd,
    input  wire logic               host_request_to_send_n,
    output logic                    device_clear_for_host_n,
    output logic                    device_request_to_send_n,
    input  wire logic               host_clear_for_device_n,
    // debug port pins
    input  wire logic               dbg_rxd,
    output logic                    dbg_txd,
    // control pins
    input  wire logic               time_capture_strobe_n,
    input  wire logic               radio_inhibit,
    // outgoing packet payload
    input  wire hufc_pkg::hufc_byte_t pkt_tx,
    input  wire logic               pkt_tx_valid,
    output logic                    pkt_tx_ready,
    // incoming packet payload
    output logic [7:0]              pkt_rx_data,
    output logic                    pkt_rx_valid,
    output logic                    pkt_rx_end,
    // debug bytes
    input  wire logic [7:0]         dbg_tx_data,
    input  wire logic               dbg_tx_valid,
    output logic                    dbg_tx_ready,
    output logic [7:0]              dbg_rx_data,
    output logic                    dbg_rx_valid,
    // time and radio
    input  wire logic               time_read_request,
    input  wire logic               radio_op_request,
    input  wire logic               radio_op_busy,
    output logic                    radio_op_grant,
    output logic                    radio_blocked,
    // port activity, for power management
    output logic                    app_port_active,
    output logic                    dbg_port_active
);
    // ============================================================
    // frame byte helper, shared by framer and deframer
    function automatic logic is_special(input logic [7:0] b);
        is_special = (b == `HUFC_HDLC_FLAG) || (b == `HUFC_HDLC_ESC);
    endfunction : is_special

    function automatic logic [7:0] ts_byte(input logic [31:0] ts,
                                           input logic [1:0]  idx);
        ts_byte = 8'(ts >> {~idx, 3'b000});  // most significant first
    endfunction : ts_byte

    // ============================================================
    // two flop synchronisers on every host pin
    hufc_pkg::hufc_pins_t pins_raw;
    hufc_pkg::hufc_pins_t s1_q;      // metastable stage, read by s2 only
    hufc_pkg::hufc_pins_t s2_q;      // safe copy
    hufc_pkg::hufc_pins_t s3_q;      // previous value, edge detect

    assign pins_raw = '{app_rxd, dbg_rxd, host_request_to_send_n,
                        host_clear_for_device_n, time_capture_strobe_n,
                        radio_inhibit};

    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            s1_q <= hufc_pkg::hufc_pins_t'(`HUFC_PINS_RST);
            s2_q <= hufc_pkg::hufc_pins_t'(`HUFC_PINS_RST);
            s3_q <= hufc_pkg::hufc_pins_t'(`HUFC_PINS_RST);
        end else begin
            s1_q <= pins_raw;
            s2_q <= s1_q;
            s3_q <= s2_q;
        end
    end

    // ============================================================
    // character engines
    logic       app_tx_ready;
    logic       app_tx_go;
    logic [7:0] app_tx_byte;
    logic [7:0] app_rx_byte;
    logic       app_rx_valid;
    logic       app_rx_busy;
    logic       dbg_rx_busy;

    hufc_uart_core #(.DIV(`HUFC_APP_DIV)) u_app (
        .clock    (clock),
        .rst_b    (rst_b),
        .rxd      (s2_q.app_rxd),
        .tx_data  (app_tx_byte),
        .tx_valid (app_tx_go),
        .tx_ready (app_tx_ready),
        .txd      (app_txd),
        .rx_data  (app_rx_byte),
        .rx_valid (app_rx_valid),
        .rx_busy  (app_rx_busy)
    );

    hufc_uart_core #(.DIV(`HUFC_DBG_DIV)) u_dbg (
        .clock    (clock),
        .rst_b    (rst_b),
        .rxd      (s2_q.dbg_rxd),
        .tx_data  (dbg_tx_data),
        .tx_valid (dbg_tx_valid),
        .tx_ready (dbg_tx_ready),
        .txd      (dbg_txd),
        .rx_data  (dbg_rx_data),
        .rx_valid (dbg_rx_valid),
        .rx_busy  (dbg_rx_busy)
    );

    // ============================================================
    // inbound flow control: clear follows request, but is held until
    // the last character has fully arrived
    logic cts_n_q;
    wire  host_req_on = !s2_q.host_rts_n;
    wire  cts_n_d = host_req_on ? 1'b0
                  : (app_rx_busy ? cts_n_q : 1'b1);
    assign device_clear_for_host_n = cts_n_q;

    // ============================================================
    // inbound deframer
    logic       in_frame_q;   // a flag has been seen
    logic       esc_q;        // next byte is escaped
    logic       got_q;        // frame holds payload
    logic [7:0] rx_data_q;
    logic       rx_valid_q;
    logic       rx_end_q;
    wire        rx_flag = app_rx_valid && (app_rx_byte == `HUFC_HDLC_FLAG);
    wire        rx_esc  = app_rx_valid && (app_rx_byte == `HUFC_HDLC_ESC);
    wire        rx_pay  = app_rx_valid && in_frame_q && !is_special(app_rx_byte);
    wire [7:0]  rx_fix  = esc_q ? (app_rx_byte ^ `HUFC_HDLC_XOR) : app_rx_byte;

    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            in_frame_q <= 1'b0;
            esc_q      <= 1'b0;
            got_q      <= 1'b0;
            rx_data_q  <= 8'h00;
            rx_valid_q <= 1'b0;
            rx_end_q   <= 1'b0;
            cts_n_q    <= 1'b1;
        end else begin
            cts_n_q    <= cts_n_d;
            rx_valid_q <= rx_pay;
            rx_end_q   <= rx_flag && in_frame_q && got_q;
            if (rx_pay) begin
                rx_data_q <= rx_fix;
            end
            if (rx_flag) begin
                in_frame_q <= 1'b1;
                esc_q      <= 1'b0;
                got_q      <= 1'b0;
            end else if (rx_esc) begin
                esc_q <= 1'b1;
            end else if (rx_pay) begin
                esc_q <= 1'b0;
                got_q <= 1'b1;
            end
        end
    end

    assign pkt_rx_data  = rx_data_q;
    assign pkt_rx_valid = rx_valid_q;
    assign pkt_rx_end   = rx_end_q;

    // ============================================================
    // timestamp capture; the strobe edge latches after the two flop synchroniser, a request
    // latches when software asks, whatever its processing delay
    logic [31:0] ts_cnt_q;    // free running clock count
    logic [31:0] ts_latch_q;  // last captured time
    logic [31:0] ts_send_q;   // copy being sent, immune to new captures
    logic        time_pend_q;
    wire         strobe_rise = s2_q.time_n && !s3_q.time_n;
    wire         capture     = strobe_rise || time_read_request;

    // ============================================================
    // outbound framer
    hufc_pkg::hufc_tx_st_t tx_st_q;
    hufc_pkg::hufc_tx_st_t tx_st_d;
    logic        time_sel_q;  // current packet is a time report
    logic [1:0]  time_idx_q;
    logic [15:0] gap_cnt_q;
    logic        rts_n_q;

    wire       take_time = (tx_st_q == hufc_pkg::S_IDLE) && time_pend_q;
    wire       take_user = (tx_st_q == hufc_pkg::S_IDLE) && pkt_tx_valid;
    wire [7:0] cur_byte  = time_sel_q ? ts_byte(ts_send_q, time_idx_q)
                                      : pkt_tx.data;
    wire       cur_last  = time_sel_q ? (time_idx_q == `HUFC_TS_LAST_IDX)
                                      : pkt_tx.last;
    wire       cur_ok    = time_sel_q || pkt_tx_valid;
    wire       in_data   = (tx_st_q == hufc_pkg::S_DATA);
    wire       in_esc    = (tx_st_q == hufc_pkg::S_ESC);
    wire       in_flag   = (tx_st_q == hufc_pkg::S_OPEN)
                        || (tx_st_q == hufc_pkg::S_CLOSE);
    wire       stuff     = in_data && is_special(cur_byte);
    wire       consume   = app_tx_ready && cur_ok
                        && ((in_data && !stuff) || in_esc);

    assign app_tx_go   = app_tx_ready && (in_flag || ((in_data || in_esc)
                                                     && cur_ok));
    assign app_tx_byte = in_flag ? `HUFC_HDLC_FLAG
                       : stuff   ? `HUFC_HDLC_ESC
                       : in_esc  ? (cur_byte ^ `HUFC_HDLC_XOR) : cur_byte;
    assign pkt_tx_ready = consume && !time_sel_q;

    // next state of the framer
    always_comb begin
        tx_st_d = tx_st_q;
        case (tx_st_q)
            hufc_pkg::S_IDLE:
                if (take_time || take_user) tx_st_d = hufc_pkg::S_REQ;
            hufc_pkg::S_REQ:
                if (!s2_q.host_cts_n) tx_st_d = hufc_pkg::S_OPEN;
            hufc_pkg::S_OPEN:
                if (app_tx_ready) tx_st_d = hufc_pkg::S_DATA;
            hufc_pkg::S_DATA: begin
                if (stuff && app_tx_ready && cur_ok) tx_st_d = hufc_pkg::S_ESC;
                else if (consume && cur_last) tx_st_d = hufc_pkg::S_CLOSE;
            end
            hufc_pkg::S_ESC:
                if (consume) tx_st_d = cur_last ? hufc_pkg::S_CLOSE
                                                : hufc_pkg::S_DATA;
            hufc_pkg::S_CLOSE:
                if (app_tx_ready) tx_st_d = hufc_pkg::S_GAP;
            hufc_pkg::S_GAP:
                if (app_tx_ready && gap_cnt_q == 16'h0000)
                    tx_st_d = hufc_pkg::S_IDLE;
            default: tx_st_d = hufc_pkg::S_IDLE;
        endcase
    end

    // request stays up until the closing flag has left the wire
    wire rts_n_d = (tx_st_q == hufc_pkg::S_IDLE)
                || ((tx_st_q == hufc_pkg::S_GAP) && app_tx_ready);

    // framer, timestamp and gap registers
    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            tx_st_q     <= hufc_pkg::S_IDLE;
            time_sel_q  <= 1'b0;
            time_idx_q  <= 2'h0;
            gap_cnt_q   <= 16'h0000;
            rts_n_q     <= 1'b1;
            ts_cnt_q    <= 32'h0000_0000;
            ts_latch_q  <= 32'h0000_0000;
            ts_send_q   <= 32'h0000_0000;
            time_pend_q <= 1'b0;
        end else begin
            tx_st_q     <= tx_st_d;
            rts_n_q     <= rts_n_d;
            ts_cnt_q    <= ts_cnt_q + 32'h0000_0001;
            // a capture in the cycle of the take is kept pending
            time_pend_q <= capture || (time_pend_q && !take_time);
            if (capture) ts_latch_q <= ts_cnt_q;
            if (tx_st_q == hufc_pkg::S_IDLE) begin
                time_sel_q <= take_time;
                time_idx_q <= 2'h0;
                ts_send_q  <= capture ? ts_cnt_q : ts_latch_q;
            end else if (consume && time_sel_q) begin
                time_idx_q <= time_idx_q + 2'h1;
            end
            if (!app_tx_ready || tx_st_q != hufc_pkg::S_GAP)
                gap_cnt_q <= `HUFC_TX_GAP_CYC;
            else if (gap_cnt_q != 16'h0000)
                gap_cnt_q <= gap_cnt_q - 16'h0001;
        end
    end

    assign device_request_to_send_n = rts_n_q;

    // ============================================================
    // radio inhibit: new operations refused at once; the blocked
    // state only takes over once any running operation has ended
    logic blocked_q;
    logic app_act_q;
    logic dbg_act_q;

    assign radio_op_grant = radio_op_request && !s2_q.radio_inhibit;
    assign radio_blocked  = blocked_q;
    assign app_port_active = app_act_q;
    assign dbg_port_active = dbg_act_q;

    // block state and port activity flags
    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            blocked_q <= 1'b0;
            app_act_q <= 1'b0;
            dbg_act_q <= 1'b0;
        end else begin
            if (!radio_op_busy) blocked_q <= s2_q.radio_inhibit;
            app_act_q <= app_rx_busy || !app_tx_ready;
            dbg_act_q <= dbg_rx_busy || !dbg_tx_ready;
        end
    end

    // ============================================================
    // checks
    cts_answer_a:
    assert property (@(posedge clock) disable iff (!rst_b)
        !host_request_to_send_n [*3] |=> !device_clear_for_host_n)
        else $error("clear not given to host request");

    cts_release_a:
    assert property (@(posedge clock) disable iff (!rst_b)
        $rose(device_clear_for_host_n) |-> $past(s2_q.host_rts_n)
            && !$past(app_rx_busy)) else $error("clear dropped early");

    rts_request_a:
    assert property (@(posedge clock) disable iff (!rst_b)
        (tx_st_q == hufc_pkg::S_REQ) |=> !device_request_to_send_n)
        else $error("request not raised");

    tx_gate_a:
    assert property (@(posedge clock) disable iff (!rst_b)
        (tx_st_q == hufc_pkg::S_REQ) ##1 (tx_st_q == hufc_pkg::S_OPEN)
        |-> !$past(s2_q.host_cts_n)) else $error("sent without clear");

    gap_hold_a:
    assert property (@(posedge clock) disable iff (!rst_b)
        (tx_st_q == hufc_pkg::S_GAP && app_tx_ready && gap_cnt_q != 16'h0000)
        |=> (tx_st_q == hufc_pkg::S_GAP) && device_request_to_send_n)
        else $error("idle gap cut short");

    time_pend_a:
    assert property (@(posedge clock) disable iff (!rst_b)
        capture |=> time_pend_q) else $error("time report lost");

    strobe_latch_a:
    assert property (@(posedge clock) disable iff (!rst_b)
        strobe_rise |=> ts_latch_q == $past(ts_cnt_q))
        else $error("strobe time not latched");

    radio_refuse_a:
    assert property (@(posedge clock) disable iff (!rst_b)
        radio_inhibit [*3] |-> !radio_op_grant)
        else $error("radio granted while inhibited");

    radio_finish_a:
    assert property (@(posedge clock) disable iff (!rst_b)
        (radio_op_busy && !radio_blocked) |=> !radio_blocked)
        else $error("block hit a running operation");

    unescape_a:
    assert property (@(posedge clock) disable iff (!rst_b)
        (rx_pay && esc_q) |=> pkt_rx_valid
            && pkt_rx_data == ($past(app_rx_byte) ^ `HUFC_HDLC_XOR))
        else $error("escaped byte not restored");

endmodule : hufc_host_uart

`default_nettype wire

// ### testbench/hufc_host_model.sv
`timescale 1ns/10ps
`default_nettype none
// ============================================================
// host side: sends 8N1 characters, collects device characters
module hufc_host_model #(
    parameter int D = 174 // clocks per bit, 115200 baud
) (
    input  wire logic clock,
    input  wire logic txd,
    output var logic  rxd,
    output var logic  rts_n,
    output var logic  cts_n
);
    logic [7:0] b;     // character being collected
    logic [7:0] rq[$]; // characters seen from the device
    // idle line, no request, not ready; bench moves the two lines
    initial begin
        rxd   = 1'b1;
        rts_n = 1'b1;
        cts_n = 1'b1;
    end
    // one character: start low, lsb first, one stop, no parity
    task automatic tx(input logic [7:0] v);
        logic [9:0] f;
        f = {1'b1, v, 1'b0};
        for (int i = 0; i < 10; i++) begin
            rxd <= f[i];
            repeat (D) @(posedge clock);
        end
    endtask : tx
    // mid-bit sampling, so a wrong rate garbles the bytes
    always begin
        @(negedge txd);
        repeat (D / 2) @(posedge clock);
        for (int i = 0; i < 8; i++) begin
            repeat (D) @(posedge clock);
            b[i] = txd;
        end
        repeat (D) @(posedge clock);
        rq.push_back(b);
    end
endmodule : hufc_host_model
`default_nettype wire

// ### testbench/hufc_host_uart_test.sv
`timescale 1ns/10ps
`default_nettype none
`define CHK(a, e) begin check_count++; if ((a) !== (e)) begin \
    mismatches++; $display("BAD t=%0t got %h exp %h", $time, a, e); end end
module hufc_host_uart_test;
    // ============================================================
    // nets and bench state
    logic clock = 1'b0, rst_b = 1'b0;
    logic app_rxd, app_txd, dbg_txd, pkt_tx_ready, pkt_rx_valid;
    logic host_request_to_send_n, device_clear_for_host_n;
    logic host_clear_for_device_n, device_request_to_send_n;
    logic pkt_rx_end, dbg_tx_ready, dbg_rx_valid, radio_op_grant;
    logic [7:0] pkt_rx_data, dbg_rx_data, last_rx, last_dbg;
    logic radio_blocked, radio_inhibit = 1'b0, radio_op_request = 1'b0;
    logic radio_op_busy = 1'b0, pkt_tx_valid = 1'b0, dbg_tx_valid = 1'b0;
    logic time_capture_strobe_n = 1'b1, time_read_request = 1'b0;
    logic dbg_port_active;
    int cyc = 0, t0; // bench edge count; timestamp counts from release
    logic [7:0] dbg_tx_data = 8'h00;
    hufc_pkg::hufc_byte_t pkt_tx = '0;
    int mismatches = 0, check_count = 0, w, n_rx = 0, n_end = 0, n_dbg = 0;
    // rows {payload expected, payload, wire byte}
    logic [16:0] rows [5] = '{17'h0007e, 17'h14141, 17'h0007d,
                              17'h17e5e, 17'h0007e};
    logic [7:0] ow [4] = '{8'h7e, 8'h7d, 8'h5e, 8'h7e}; // stuffed out
    always #25 clock = ~clock;
    // debug port looped back on itself, so both halves are exercised
    hufc_host_uart i_dut (.clock, .rst_b, .app_rxd, .app_txd,
        .host_request_to_send_n, .device_clear_for_host_n,
        .device_request_to_send_n, .host_clear_for_device_n,
        .dbg_rxd(dbg_txd), .dbg_txd, .time_capture_strobe_n,
        .radio_inhibit, .pkt_tx, .pkt_tx_valid, .pkt_tx_ready,
        .pkt_rx_data, .pkt_rx_valid, .pkt_rx_end, .dbg_tx_data,
        .dbg_tx_valid, .dbg_tx_ready, .dbg_rx_data, .dbg_rx_valid,
        .time_read_request, .radio_op_request, .radio_op_busy,
        .radio_op_grant, .radio_blocked, .app_port_active(),
        .dbg_port_active);
    hufc_host_model i_host (.clock, .txd(app_txd), .rxd(app_rxd),
        .rts_n(host_request_to_send_n), .cts_n(host_clear_for_device_n));
    // one-cycle pulses are caught here, at the cycle they stand
    always @(posedge clock) begin
        cyc <= cyc + 1;
        if (pkt_rx_valid === 1'b1) begin
            last_rx <= pkt_rx_data;
            n_rx <= n_rx + 1;
        end
        if (pkt_rx_end === 1'b1) n_end <= n_end + 1;
        if (dbg_rx_valid === 1'b1) begin
            last_dbg <= dbg_rx_data;
            n_dbg <= n_dbg + 1;
        end
        if (pkt_tx_ready === 1'b1) pkt_tx_valid <= 1'b0;
    end
    task automatic report_and_stop();
        $display("checks %0d mismatches %0d", check_count, mismatches);
        if (mismatches == 0 && check_count > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    endtask : report_and_stop
    // watchdog well past the expected 42.5k cycles
    initial begin
        repeat (80000) @(posedge clock);
        mismatches++;
        report_and_stop();
    end
    // ============================================================
    // main sequence
    initial begin
        repeat (8) @(posedge clock);
        `CHK(app_txd, 1'b1)
        `CHK(device_clear_for_host_n, 1'b1)
        `CHK(device_request_to_send_n, 1'b1)
        rst_b <= 1'b1;
        repeat (4) @(posedge clock);
        i_host.rts_n <= 1'b0;
        for (w = 0; w < 20 && device_clear_for_host_n !== 1'b0; w++)
            @(posedge clock);
        `CHK(device_clear_for_host_n, 1'b0)
        foreach (rows[i]) begin
            i_host.tx(rows[i][7:0]);
            if (rows[i][16]) `CHK(last_rx, rows[i][15:8])
        end
        `CHK(n_rx, 2)
        `CHK(n_end, 1)
        i_host.rts_n <= 1'b1;
        for (w = 0; w < 20 && device_clear_for_host_n !== 1'b1; w++)
            @(posedge clock);
        `CHK(device_clear_for_host_n, 1'b1)
        // request left high: no flow control, bytes still taken
        i_host.tx(8'h7e);
        i_host.tx(8'h41);
        i_host.tx(8'h7e);
        `CHK(n_rx, 3)
        `CHK(device_clear_for_host_n, 1'b1)
        // outbound: host not ready, so the packet must wait
        pkt_tx <= '{data: 8'h7e, last: 1'b1};
        pkt_tx_valid <= 1'b1;
        repeat (50) @(posedge clock);
        `CHK(device_request_to_send_n, 1'b0)
        `CHK(app_txd, 1'b1)
        i_host.cts_n <= 1'b0;
        for (w = 0; w < 9000 && device_request_to_send_n !== 1'b1; w++)
            @(posedge clock);
        foreach (ow[i]) `CHK(i_host.rq[i], ow[i])
        pkt_tx <= '{data: 8'h33, last: 1'b1};
        pkt_tx_valid <= 1'b1;
        repeat (1600) @(posedge clock);
        `CHK(device_request_to_send_n, 1'b1)
        for (w = 0; w < 400 && device_request_to_send_n !== 1'b0; w++)
            @(posedge clock);
        `CHK(device_request_to_send_n, 1'b0)
        // radio: inhibit during a running operation
        radio_op_request <= 1'b1;
        radio_op_busy <= 1'b1;
        repeat (4) @(posedge clock);
        `CHK(radio_op_grant, 1'b1)
        radio_inhibit <= 1'b1;
        repeat (4) @(posedge clock);
        `CHK(radio_op_grant, 1'b0)
        `CHK(radio_blocked, 1'b0)
        radio_op_busy <= 1'b0;
        repeat (4) @(posedge clock);
        `CHK(radio_blocked, 1'b1)
        // time: strobe rise latches 2 sync edges later, request at once
        time_capture_strobe_n <= 1'b0;
        repeat (4) @(posedge clock);
        time_capture_strobe_n <= 1'b1;
        t0 = cyc;
        repeat (6) @(posedge clock);
        `CHK(i_dut.ts_latch_q, 32'(t0 - 5))
        `CHK(i_dut.time_pend_q, 1'b1)
        time_read_request <= 1'b1;
        t0 = cyc;
        @(posedge clock);
        time_read_request <= 1'b0;
        repeat (2) @(posedge clock);
        `CHK(i_dut.ts_latch_q, 32'(t0 - 7))
        // debug byte through the loop
        dbg_tx_data <= 8'ha5;
        dbg_tx_valid <= 1'b1;
        @(posedge clock);
        dbg_tx_valid <= 1'b0;
        repeat (2) @(posedge clock);
        `CHK(dbg_port_active, 1'b1)
        for (w = 0; w < 25000 && n_dbg == 0; w++) @(posedge clock);
        `CHK(last_dbg, 8'ha5)
        `CHK(i_host.rq[4], 8'h7e)
        `CHK(i_host.rq[5], 8'h33)
        `CHK(i_host.rq[6], 8'h7e)
        `CHK(i_host.rq[7], 8'h7e)
        report_and_stop();
    end
endmodule : hufc_host_uart_test
`default_nettype wire
